// ==== rtl/serial_io_expander.sv ====
`timescale 1ns/100ps
module serial_io_expander
  import serial_io_pkg::*;
#(
  parameter int unsigned BOOST_CYCLES = BOOST_CYCLES_DFLT
) (
  input  wire logic       mclk,
  input  wire logic       rst,
  input  wire logic       ce,
  input  wire logic       smb_clk,
  input  wire logic       smb_data_i,
  output      logic       smb_data_o,
  output      logic       smb_data_oe,
  input  wire logic [2:0] addr_sel,
  input  wire logic [7:0] io_pin_i,
  output      logic [7:0] io_pin_o,
  output      logic [7:0] io_pin_oe,
  output      logic       alert_n_o,
  output      logic       alert_n_oe
);

  typedef struct packed {
    logic [1:0] scl_s;
    logic [1:0] sda_s;
    logic       scl_p;
    logic       sda_p;
    logic [7:0] pin_s0;
    logic [7:0] pin_s1;
    logic [7:0] pin_p;
    logic [2:0] strap_s0;
    logic [2:0] strap_s1;
    logic [1:0] boot_cnt;
    logic [6:0] own_addr;
    bus_state_t st;
    logic [3:0] cnt;
    logic [7:0] shift;
    logic       rw;
    logic       alert_response_addr;
    logic [7:0] cmd;
    logic       sda_oe;
    io_regs_t   regs;
    logic [7:0] flags;
    logic       alert;
    logic [7:0] pin_o;
    logic [7:0] pin_oe;
  } top_state_t;

  top_state_t   q;
  top_state_t   d;
  cooling_out_t fan_o;
  logic [2:0]   speed_setting;
  logic         speed_wr;
  logic         clr_flags;
  logic         ara_done;
  logic         scl_rise;
  logic         scl_fall;
  logic         bus_start;
  logic         bus_stop;
  logic [7:0]   upper;
  logic [7:0]   is_out;
  logic [7:0]   change;
  logic         alert_ev;
  logic [7:0]   pin_read;
  logic [7:0]   drive_val;
  logic [7:0]   push_pull;

  // ----------------------------------------------------------------
  // Pin conditioning and change detection
  // ----------------------------------------------------------------
  assign scl_rise  = q.scl_s[1] & ~q.scl_p;
  assign scl_fall  = ~q.scl_s[1] & q.scl_p;
  assign bus_start = q.scl_s[1] & q.scl_p & q.sda_p & ~q.sda_s[1];
  assign bus_stop  = q.scl_s[1] & q.scl_p & ~q.sda_p & q.sda_s[1];

  assign upper     = q.regs.cooling_mode ? UPPER_PIN_MASK : 8'h00;
  assign is_out    = q.regs.pin_direction | upper;
  // The previous sample is only valid once the synchronisers have filled,
  // otherwise the reset value would look like a change on every high pin.
  assign change    = (q.boot_cnt == BOOT_SETTLED) ? ((q.pin_s1 ^ q.pin_p) & ~is_out) : 8'h00;
  assign alert_ev  = q.regs.global_irq_enable & (|(change & q.regs.change_irq_mask));
  assign pin_read  = (q.pin_s1 & ~is_out) | (q.regs.pin_value & is_out);
  assign drive_val = q.regs.cooling_mode
                   ? {fan_o.speed_outputs_n, fan_o.cooling_shutdown_n, q.regs.pin_value[3:0]}
                   : q.regs.pin_value;
  assign push_pull = q.regs.output_drive_type & ~upper;

  function automatic logic [7:0] reg_read(input logic [7:0] addr, input io_regs_t r,
                                          input logic [7:0] flags, input logic [7:0] pins,
                                          input logic [2:0] speed);
    logic [7:0] v;
    v = 8'h00;
    unique case (addr)
      REG_DEVICE_CONFIG: begin
        v[CFG_IRQ_EN_BIT]  = r.global_irq_enable;
        v[CFG_COOLING_BIT] = r.cooling_mode;
      end
      REG_PIN_DIRECTION:    v = r.pin_direction;
      REG_OUTPUT_DRIVE:     v = r.output_drive_type;
      REG_PIN_CHANGE_FLAGS: v = flags;
      REG_CHANGE_IRQ_MASK:  v = r.change_irq_mask;
      REG_PIN_VALUE:        v = pins;
      REG_COOLING_SPEED:    v = {5'h00, speed};
      default:              v = 8'h00;
    endcase
    return v;
  endfunction

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    d         = q;
    clr_flags = 1'b0;
    ara_done  = 1'b0;
    speed_wr  = 1'b0;
    d.scl_s    = {q.scl_s[0], smb_clk};
    d.sda_s    = {q.sda_s[0], smb_data_i};
    d.scl_p    = q.scl_s[1];
    d.sda_p    = q.sda_s[1];
    d.pin_s0   = io_pin_i;
    d.pin_s1   = q.pin_s0;
    d.pin_p    = q.pin_s1;
    d.strap_s0 = addr_sel;
    d.strap_s1 = q.strap_s0;
    if (q.boot_cnt != BOOT_SETTLED) begin
      d.boot_cnt = q.boot_cnt + 2'h1;
    end
    // Straps are taken once, after the synchroniser holds a real sample.
    if (q.boot_cnt == BOOT_STRAP_TAKE) begin
      d.own_addr = {CLIENT_ADDR_BASE[6:3], q.strap_s1};
    end

    unique case (q.st)
      BUS_IDLE, BUS_WAIT: begin
      end
      BUS_ADDR, BUS_CMD, BUS_WDATA: begin
        if (scl_rise) begin
          d.shift = {q.shift[6:0], q.sda_s[1]};
          d.cnt   = q.cnt + 4'h1;
        end else if (scl_fall && q.cnt == BYTE_BITS) begin
          d.cnt    = 4'h0;
          d.sda_oe = 1'b1;
          if (q.st == BUS_ADDR) begin
            d.rw  = q.shift[0];
            d.alert_response_addr = 1'b0;
            d.st  = BUS_ADDR_ACK;
            if (q.shift[7:1] == ALERT_RESPONSE_ADDR && q.shift[0] && q.alert) begin
              d.alert_response_addr = 1'b1;
            end else if (q.shift[7:1] != q.own_addr) begin
              d.sda_oe = 1'b0;
              d.st     = BUS_WAIT;
            end
          end else if (q.st == BUS_CMD) begin
            d.cmd = q.shift;
            d.st  = BUS_CMD_ACK;
          end else begin
            d.st = BUS_WDATA_ACK;
            unique case (q.cmd)
              REG_DEVICE_CONFIG: begin
                d.regs.global_irq_enable = q.shift[CFG_IRQ_EN_BIT];
                d.regs.cooling_mode      = q.shift[CFG_COOLING_BIT];
              end
              REG_PIN_DIRECTION:   d.regs.pin_direction     = q.shift;
              REG_OUTPUT_DRIVE:    d.regs.output_drive_type = q.shift;
              REG_CHANGE_IRQ_MASK: d.regs.change_irq_mask   = q.shift;
              REG_PIN_VALUE: begin
                d.regs.pin_value = (q.regs.pin_value & ~q.regs.pin_direction)
                                 | (q.shift & q.regs.pin_direction);
              end
              REG_COOLING_SPEED:   speed_wr = 1'b1;
              default: begin
              end
            endcase
          end
        end
      end
      BUS_ADDR_ACK: begin
        if (scl_fall) begin
          d.sda_oe = 1'b0;
          d.st     = BUS_CMD;
          if (q.rw) begin
            d.shift  = q.alert_response_addr ? {q.own_addr, 1'b0}
                             : reg_read(q.cmd, q.regs, q.flags, pin_read, speed_setting);
            d.sda_oe = ~d.shift[7];
            d.cnt    = 4'h1;
            d.st     = BUS_RDATA;
          end
        end
      end
      BUS_CMD_ACK: begin
        if (scl_fall) begin
          d.sda_oe = 1'b0;
          d.st     = BUS_WDATA;
        end
      end
      BUS_WDATA_ACK: begin
        if (scl_fall) begin
          d.sda_oe = 1'b0;
          d.st     = BUS_WAIT;
        end
      end
      BUS_RDATA: begin
        if (scl_fall) begin
          if (q.cnt == BYTE_BITS) begin
            d.sda_oe = 1'b0;
            d.st     = BUS_RACK;
            if (q.alert_response_addr) begin
              ara_done = 1'b1;
            end else if (q.cmd == REG_PIN_CHANGE_FLAGS) begin
              clr_flags = 1'b1;
            end
          end else begin
            d.shift  = {q.shift[6:0], 1'b0};
            d.sda_oe = ~q.shift[6];
            d.cnt    = q.cnt + 4'h1;
          end
        end
      end
      BUS_RACK: begin
        if (scl_fall) begin
          d.st = BUS_WAIT;
        end
      end
      default: d.st = BUS_IDLE;
    endcase

    if (bus_start) begin
      d.st     = BUS_ADDR;
      d.cnt    = 4'h0;
      d.sda_oe = 1'b0;
    end else if (bus_stop) begin
      d.st     = BUS_IDLE;
      d.sda_oe = 1'b0;
    end

    // A change in the clearing cycle survives: the set term wins.
    d.flags = (clr_flags ? 8'h00 : q.flags) | change;
    d.alert = ((clr_flags | ara_done) ? 1'b0 : q.alert) | alert_ev;

    for (int i = 0; i < 8; i++) begin
      d.pin_o[i]  = drive_val[i];
      d.pin_oe[i] = is_out[i] & (push_pull[i] | ~drive_val[i]);
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      q                <= '0;
      q.regs.pin_value <= RST_PIN_VALUE;
      q.own_addr       <= CLIENT_ADDR_BASE;
    end else if (ce) begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // Cooling encoder and outputs
  // ----------------------------------------------------------------
  cooling_speed_encoder #(
    .BOOST_CYCLES (BOOST_CYCLES)
  ) u_cooling (
    .mclk          (mclk),
    .rst           (rst),
    .ce            (ce),
    .speed_wr      (speed_wr),
    .speed_wdata   (q.shift[2:0]),
    .speed_setting (speed_setting),
    .cooling_out   (fan_o)
  );

  assign smb_data_o  = 1'b0;
  assign smb_data_oe = q.sda_oe;
  assign io_pin_o    = q.pin_o;
  assign io_pin_oe   = q.pin_oe;
  assign alert_n_o   = 1'b0;
  assign alert_n_oe  = q.alert;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_flags_sticky: assert property (@(posedge mclk) disable iff (rst)
    (ce && !clr_flags) |=> ((q.flags & $past(q.flags)) == $past(q.flags)))
    else $error("change flag dropped without a flag read");

  a_flags_clear: assert property (@(posedge mclk) disable iff (rst)
    (ce && clr_flags && change == 8'h00) |=> (q.flags == 8'h00))
    else $error("flag read did not clear flags");

  a_cooling_quiet: assert property (@(posedge mclk) disable iff (rst)
    (ce && q.regs.cooling_mode) |=> ((q.flags[7:4] & ~$past(q.flags[7:4])) == 4'h0))
    else $error("upper pin flagged in cooling mode");

  a_alert_cause: assert property (@(posedge mclk) disable iff (rst)
    $rose(q.alert) |-> $past(q.regs.global_irq_enable && (|(change & q.regs.change_irq_mask))))
    else $error("alert raised without enabled change");

  a_upper_open_drain: assert property (@(posedge mclk) disable iff (rst)
    (ce && q.regs.cooling_mode) |=> (io_pin_oe[7:4] == ~io_pin_o[7:4]))
    else $error("upper pin not open-drain in cooling mode");

  a_input_released: assert property (@(posedge mclk) disable iff (rst)
    (ce && !q.regs.cooling_mode) |=> ((io_pin_oe & ~$past(q.regs.pin_direction)) == 8'h00))
    else $error("input pin is driven");

  a_push_pull: assert property (@(posedge mclk) disable iff (rst)
    (ce && !q.regs.cooling_mode)
      |=> ((io_pin_oe | ~$past(q.regs.pin_direction & q.regs.output_drive_type)) == 8'hFF))
    else $error("push-pull output not driven");

  a_value_inputs: assert property (@(posedge mclk) disable iff (rst)
    (ce && q.regs.pin_direction == 8'h00) |=> (q.regs.pin_value == $past(q.regs.pin_value)))
    else $error("pin value changed while all pins are inputs");

endmodule

// ==== rtl/serial_io_pkg.sv ====
package serial_io_pkg;

  // ----------------------------------------------------------------
  // Register map and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_DEVICE_CONFIG   = 8'h00;
  localparam logic [7:0] REG_PIN_DIRECTION   = 8'h01;
  localparam logic [7:0] REG_OUTPUT_DRIVE    = 8'h02;
  localparam logic [7:0] REG_PIN_CHANGE_FLAGS = 8'h03;
  localparam logic [7:0] REG_CHANGE_IRQ_MASK = 8'h04;
  localparam logic [7:0] REG_PIN_VALUE       = 8'h05;
  localparam logic [7:0] REG_COOLING_SPEED   = 8'h06;

  localparam int         CFG_IRQ_EN_BIT      = 0;
  localparam int         CFG_COOLING_BIT     = 1;
  localparam logic [7:0] RST_REG_ZERO        = 8'h00;
  localparam logic [7:0] RST_PIN_VALUE       = 8'hFF;
  localparam logic [7:0] UPPER_PIN_MASK      = 8'hF0;

  // ----------------------------------------------------------------
  // Bus addressing
  // ----------------------------------------------------------------
  localparam logic [6:0] CLIENT_ADDR_BASE    = 7'h20;
  localparam logic [6:0] ALERT_RESPONSE_ADDR = 7'h0C;
  localparam logic [3:0] BYTE_BITS           = 4'h8;
  localparam logic [1:0] BOOT_SETTLED        = 2'h3;
  localparam logic [1:0] BOOT_STRAP_TAKE     = 2'h2;

  // ----------------------------------------------------------------
  // Cooling output timing
  // ----------------------------------------------------------------
  localparam int         CLK_HZ              = 10_000_000;
  localparam int         BOOST_MS            = 1000;
  localparam int         BOOST_CYCLES_DFLT   = (CLK_HZ / 1000) * BOOST_MS;
  localparam int         SPEED_W             = 3;
  localparam logic [2:0] SPEED_OFF           = 3'h0;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    BUS_IDLE      = 4'h0,
    BUS_ADDR      = 4'h1,
    BUS_ADDR_ACK  = 4'h2,
    BUS_CMD       = 4'h3,
    BUS_CMD_ACK   = 4'h4,
    BUS_WDATA     = 4'h5,
    BUS_WDATA_ACK = 4'h6,
    BUS_RDATA     = 4'h7,
    BUS_RACK      = 4'h8,
    BUS_WAIT      = 4'h9
  } bus_state_t;

  typedef struct packed {
    logic [2:0] speed_outputs_n;
    logic       cooling_shutdown_n;
  } cooling_out_t;

  typedef struct packed {
    logic       global_irq_enable;
    logic       cooling_mode;
    logic [7:0] pin_direction;
    logic [7:0] output_drive_type;
    logic [7:0] change_irq_mask;
    logic [7:0] pin_value;
  } io_regs_t;

endpackage

// ==== rtl/cooling_speed_encoder.sv ====
`timescale 1ns/100ps
module cooling_speed_encoder
  import serial_io_pkg::*;
#(
  parameter int unsigned BOOST_CYCLES = BOOST_CYCLES_DFLT
) (
  input  wire logic               mclk,
  input  wire logic               rst,
  input  wire logic               ce,
  input  wire logic               speed_wr,
  input  wire logic [SPEED_W-1:0] speed_wdata,
  output      logic [SPEED_W-1:0] speed_setting,
  output      cooling_out_t       cooling_out
);

  localparam int CW = $clog2(BOOST_CYCLES + 1);

  typedef struct packed {
    logic [SPEED_W-1:0] speed;
    logic               boosting;
    logic [CW-1:0]      boost_cnt;
    cooling_out_t       pins;
  } enc_state_t;

  enc_state_t q;
  enc_state_t d;

  always_comb begin
    d = q;
    if (q.boosting) begin
      if (q.boost_cnt == '0) begin
        d.boosting = 1'b0;
      end else begin
        d.boost_cnt = q.boost_cnt - CW'(1);
      end
    end
    if (speed_wr) begin
      d.speed = speed_wdata;
      // Only an off-to-running write restarts the boost interval.
      if (q.speed == SPEED_OFF && speed_wdata != SPEED_OFF) begin
        d.boosting  = 1'b1;
        d.boost_cnt = CW'(BOOST_CYCLES - 1);
      end else if (speed_wdata == SPEED_OFF) begin
        d.boosting = 1'b0;
      end
    end
    if (d.boosting) begin
      d.pins.speed_outputs_n    = '0;
      d.pins.cooling_shutdown_n = 1'b1;
    end else begin
      d.pins.speed_outputs_n    = ~d.speed;
      d.pins.cooling_shutdown_n = |d.speed;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      q <= '0;
      q.pins.speed_outputs_n <= '1;
    end else if (ce) begin
      q <= d;
    end
  end

  assign speed_setting = q.speed;
  assign cooling_out   = q.pins;

  a_boost_start: assert property (@(posedge mclk) disable iff (rst)
    (ce && speed_wr && q.speed == SPEED_OFF && speed_wdata != SPEED_OFF)
      |=> (cooling_out.speed_outputs_n == 3'h0 && cooling_out.cooling_shutdown_n))
    else $error("boost pattern not applied after start from off");

  a_speed_pattern: assert property (@(posedge mclk) disable iff (rst)
    (ce && !d.boosting) |=> (cooling_out.speed_outputs_n == ~speed_setting
      && cooling_out.cooling_shutdown_n == (speed_setting != SPEED_OFF)))
    else $error("speed outputs do not follow setting");

endmodule

// ==== verification/smb_host_model.sv ====
`timescale 1ns/100ps
// ----------------------------------------------------------------
// Two-wire bus host, paced on the system clock
// ----------------------------------------------------------------
module smb_host_model (
  input  wire logic mclk,
  input  wire logic sda,
  output      logic scl,
  output      logic sda_oe
);
  // Each bus-clock phase lasts four system cycles (800 ns a period). Read bits
  // are taken late in the high phase, well clear of the device's 3-4 cycle lag.
  initial begin
    scl    = 1'b1;
    sda_oe = 1'b0;
  end

  task automatic wt(input int n);
    repeat (n) @(posedge mclk);
  endtask

  task automatic put(input logic b);
    sda_oe <= !b;
    wt(2);
    scl <= 1'b1;
    wt(4);
    scl <= 1'b0;
    wt(2);
  endtask

  task automatic get(output logic b);
    sda_oe <= 1'b0;
    wt(2);
    scl <= 1'b1;
    wt(3);
    @(negedge mclk);
    b = sda;
    wt(1);
    scl <= 1'b0;
    wt(2);
  endtask

  task automatic send(input logic [7:0] v, output logic k);
    logic a;
    for (int i = 7; i >= 0; i--) put(v[i]);
    get(a);
    k = !a;
  endtask

  // Single-byte write or read; the command byte picks the register.
  task automatic xfer(input logic [6:0] a, input logic rd, input logic use_cmd, input logic [7:0] cmd,
                      input logic [7:0] wd, output logic [7:0] rdv, output logic ok);
    logic k;
    ok = 1'b1;
    rdv = 8'h00;
    wt(1);
    sda_oe <= 1'b1;
    wt(4);
    scl <= 1'b0;
    wt(2);
    if (use_cmd) begin
      send({a, 1'b0}, k);
      ok &= k;
      send(cmd, k);
      ok &= k;
      if (!rd) begin
        send(wd, k);
        ok &= k;
      end else begin
        sda_oe <= 1'b0;
        wt(2);
        scl <= 1'b1;
        wt(4);
        sda_oe <= 1'b1;
        wt(4);
        scl <= 1'b0;
        wt(2);
      end
    end
    if (rd) begin
      send({a, 1'b1}, k);
      ok &= k;
      for (int i = 7; i >= 0; i--) get(rdv[i]);
      put(1'b1);
    end
    sda_oe <= 1'b1;
    wt(2);
    scl <= 1'b1;
    wt(4);
    sda_oe <= 1'b0;
    wt(4);
  endtask
endmodule

// ==== verification/testbench.sv ====
`timescale 1ns/100ps
module testbench;
  import serial_io_pkg::*;
  localparam int unsigned BOOST    = 200;
  localparam logic [6:0]  OWN_ADDR = 7'h25;
  logic        mclk;
  logic        rst;
  logic        ce;
  logic [2:0]  addr_sel;
  logic [7:0]  ext_q;
  logic        smb_clk;
  logic        host_oe;
  logic        smb_data_o;
  logic        smb_data_oe;
  logic [7:0]  io_pin_o;
  logic [7:0]  io_pin_oe;
  logic        alert_n_o;
  logic        alert_n_oe;
  wire logic   sda;
  wire logic [7:0] io_lvl;
  int          fail_count;
  int          n_compared;
  logic [7:0]  rv;
  logic        ok;
  logic [23:0] rows [8];

  // Open-drain data line with pull-up; pins show whoever drives them.
  assign sda    = !host_oe & (!smb_data_oe | smb_data_o);
  assign io_lvl = (io_pin_o & io_pin_oe) | (ext_q & ~io_pin_oe);

  serial_io_expander #(.BOOST_CYCLES(BOOST)) i_serial_io_expander (
    .mclk(mclk), .rst(rst), .ce(ce), .smb_clk(smb_clk), .smb_data_i(sda), .smb_data_o(smb_data_o),
    .smb_data_oe(smb_data_oe), .addr_sel(addr_sel), .io_pin_i(io_lvl), .io_pin_o(io_pin_o),
    .io_pin_oe(io_pin_oe), .alert_n_o(alert_n_o), .alert_n_oe(alert_n_oe));

  smb_host_model i_smb_host_model (.mclk(mclk), .sda(sda), .scl(smb_clk), .sda_oe(host_oe));

  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  // ----------------------------------------------------------------
  // Shared checks and bus cycles
  // ----------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] c, input logic [7:0] d);
    i_smb_host_model.xfer(OWN_ADDR, 1'b0, 1'b1, c, d, rv, ok);
    chk({15'h0000, ok}, 16'h0001, $sformatf("write ack %h", c));
  endtask

  task automatic rd(input logic [7:0] c, input logic [7:0] e);
    i_smb_host_model.xfer(OWN_ADDR, 1'b1, 1'b1, c, 8'h00, rv, ok);
    chk({7'h00, ok, rv}, {8'h01, e}, $sformatf("read %h", c));
  endtask

  task automatic clr_flags();
    i_smb_host_model.xfer(OWN_ADDR, 1'b1, 1'b1, REG_PIN_CHANGE_FLAGS, 8'h00, rv, ok);
  endtask

  task automatic pins(input logic [7:0] eo, input logic [7:0] v);
    @(negedge mclk);
    chk({io_pin_oe, io_pin_o & io_pin_oe}, {eo, v & eo}, "pins");
  endtask

  // Upper pins carry {speed_n[2:0], shutdown_n}, open-drain, low nibble idle.
  task automatic fan(input logic [2:0] s);
    pins({s, ~(|s), 4'h0}, {~s, |s, 4'h0});
  endtask

  task automatic setx(input logic [7:0] v);
    @(posedge mclk);
    ext_q <= v;
  endtask

  task automatic alert_is(input logic e);
    repeat (8) @(posedge mclk);
    @(negedge mclk);
    chk({14'h0000, alert_n_oe, alert_n_o}, {14'h0000, e, 1'b0}, "alert");
  endtask

  task automatic final_report();
    if (fail_count == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (40000) @(posedge mclk);
    fail_count++;
    final_report();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    fail_count = 0;
    n_compared = 0;
    rst = 1'b1;
    ce = 1'b1;
    addr_sel = 3'h5;
    ext_q = 8'hFF;
    rows = '{24'h010F0F, 24'h025A5A, 24'h04C3C3, 24'h060505, 24'h060000, 24'h000101, 24'h07AA00, 24'h03FF00};
    repeat (6) @(posedge mclk);
    rst <= 1'b0;
    repeat (12) @(posedge mclk);
    pins(8'h00, 8'h00);
    for (int r = 0; r < 7; r++) rd(r[7:0], (r == 5) ? RST_PIN_VALUE : RST_REG_ZERO);
    for (int r = 0; r < 8; r++) begin
      wr(rows[r][23:16], rows[r][15:8]);
      rd(rows[r][23:16], rows[r][7:0]);
    end
    // A foreign address must be left unanswered and change nothing.
    i_smb_host_model.xfer(7'h20, 1'b0, 1'b1, REG_PIN_DIRECTION, 8'hFF, rv, ok);
    chk({15'h0000, ok}, 16'h0000, "foreign address acked");
    rd(REG_PIN_DIRECTION, 8'h0F);
    wr(REG_OUTPUT_DRIVE, 8'h05);
    setx(8'hCF);
    wr(REG_PIN_VALUE, 8'h5A);
    pins(8'h05, 8'h5A);
    rd(REG_PIN_VALUE, 8'hCA);
    alert_is(1'b0);
    rd(REG_PIN_CHANGE_FLAGS, 8'h30);
    rd(REG_PIN_CHANGE_FLAGS, 8'h00);
    wr(REG_PIN_DIRECTION, 8'hFF);
    pins(8'h05, 8'hFA);
    rd(REG_PIN_VALUE, 8'hFA);
    // Interrupt path: disabled, masked, raised, then serviced twice.
    wr(REG_PIN_DIRECTION, 8'h00);
    wr(REG_PIN_VALUE, 8'h00);
    wr(REG_DEVICE_CONFIG, 8'h00);
    clr_flags();
    setx(8'hCE);
    alert_is(1'b0);
    rd(REG_PIN_CHANGE_FLAGS, 8'h01);
    wr(REG_DEVICE_CONFIG, 8'h01);
    // Pin 2 is masked off, so its change may only show as a flag.
    setx(8'hCA);
    alert_is(1'b0);
    setx(8'hCB);
    alert_is(1'b1);
    rd(REG_PIN_CHANGE_FLAGS, 8'h05);
    alert_is(1'b0);
    setx(8'hCC);
    alert_is(1'b1);
    i_smb_host_model.xfer(ALERT_RESPONSE_ADDR, 1'b1, 1'b0, 8'h00, 8'h00, rv, ok);
    chk({7'h00, ok, rv}, {8'h01, OWN_ADDR, 1'b0}, "alert response");
    alert_is(1'b0);
    // Cooling mode: upper pins forced open-drain, silent, fed by speed.
    wr(REG_DEVICE_CONFIG, 8'h03);
    wr(REG_PIN_DIRECTION, 8'hF0);
    wr(REG_OUTPUT_DRIVE, 8'hF0);
    wr(REG_CHANGE_IRQ_MASK, 8'hFF);
    clr_flags();
    fan(3'h0);
    setx(8'h0C);
    alert_is(1'b0);
    rd(REG_PIN_CHANGE_FLAGS, 8'h00);
    wr(REG_COOLING_SPEED, 8'h03);
    fan(3'h7);
    repeat (BOOST) @(posedge mclk);
    fan(3'h3);
    for (int s = 1; s < 8; s++) begin
      wr(REG_COOLING_SPEED, s[7:0]);
      fan(s[2:0]);
    end
    wr(REG_PIN_VALUE, 8'h0F);
    fan(3'h7);
    wr(REG_COOLING_SPEED, 8'h00);
    fan(3'h0);
    wr(REG_COOLING_SPEED, 8'h01);
    fan(3'h7);
    repeat (BOOST) @(posedge mclk);
    fan(3'h1);
    rd(REG_COOLING_SPEED, 8'h01);
    final_report();
  end
endmodule
